// ==== src/integer_mul_div_unit.sv ====
// Integer multiply and divide execution unit for a 64-bit core pipeline.
// Assumes the issue logic holds a request until it is accepted.
//
// Overview of operation
// RL1: product_low returns low register-width bits of the product.
// RL2: High product forms return upper half, signed-signed, unsigned, signed-unsigned.
// RL3: product_word multiplies low 32 bits, sign-extends the low 32 result bits.
// RL4: Full-width quotients divide signed or unsigned, rounded towards zero.
// RL5: Remainders follow their division; signed remainder takes dividend sign.
// RL6: Dividend equals divisor times quotient plus remainder, except overflow.
// RL7: Word quotients divide low 32 bits and sign-extend the 32-bit quotient.
// RL8: Word remainders always sign-extend, also when the divisor is zero.
// RL9: Divide by zero gives an all-ones quotient at operation width.
// RL10: Divide by zero gives the dividend as remainder.
// RL11: Most-negative divided by minus one gives dividend quotient, zero remainder.
// RL12: Unsigned division never overflows; only zero divisor is special.
// RL13: Special cases use register width, or 32 bits for word forms.
// RL14: High then low product with same sources may be fused.
// RL15: Divide then remainder with same sources may be fused.
// RL16: Multiply-only option keeps all multiply forms, drops divide forms.
// RL17: Zero divisor and overflow raise no trap, only defined results.
`timescale 1ns/1ps
`default_nettype none
module integer_mul_div_unit
   import muldiv_pkg::*;
#(
   parameter bit multiply_only_option = 1'b0
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic req_valid,
   output logic req_ready,
   input wire request_t req,
   output logic ans_valid,
   output answer_t ans,
   output logic illegal_op
);

   localparam int w = register_width;

   logic rst_sync1_r;
   logic rst_n;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_sync1_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_sync1_r <= 1'b1;
         rst_n <= rst_sync1_r;
      end
   end

   typedef enum logic [1:0] {st_idle, st_div, st_answer} state_t;
   state_t state_r;

   request_t held_r;
   logic [w-1:0] result_r;
   logic valid_r;
   logic illegal_r;
   logic last_high_r;
   logic [w-1:0] last_a_r;
   logic [w-1:0] last_b_r;
   logic [2*w-1:0] last_prod_r;
   logic last_div_r;
   logic last_signed_r;
   logic last_word_r;
   logic [w-1:0] last_quot_r;
   logic [w-1:0] last_rem_r;

   logic is_mul;
   logic is_div;
   logic is_word;
   logic is_signed;
   logic is_rem;
   logic accept;

   always_comb
   begin
      is_mul = (req.op inside {op_product_low, op_product_high_ss,
         op_product_high_uu, op_product_high_su, op_product_word});
      is_div = !is_mul;
      is_word = (req.op inside {op_product_word, op_quotient_word_signed,
         op_quotient_word_unsigned, op_residue_word_signed,
         op_residue_word_unsigned});
      is_signed = (req.op inside {op_quotient_signed, op_residue_signed,
         op_quotient_word_signed, op_residue_word_signed});
      is_rem = (req.op inside {op_residue_signed, op_residue_unsigned,
         op_residue_word_signed, op_residue_word_unsigned});
   end

   assign req_ready = (state_r == st_idle);
   assign accept = req_valid && req_ready;

   // Multiplier: one signed 65x65 product covers all sign mixes
   logic [w:0] mul_a;
   logic [w:0] mul_b;
   logic signed [2*w+1:0] prod_full;
   logic [2*w-1:0] product;
   logic [w-1:0] mul_result;

   always_comb
   begin
      mul_a = {1'b0, req.src_a};
      mul_b = {1'b0, req.src_b};
      if (req.op == op_product_high_ss || req.op == op_product_high_su)
         mul_a = {req.src_a[w-1], req.src_a}; // see RL2
      if (req.op == op_product_high_ss)
         mul_b = {req.src_b[w-1], req.src_b}; // see RL2
   end

   assign prod_full = $signed(mul_a) * $signed(mul_b);

   always_comb
   begin
      product = prod_full[2*w-1:0];
      // Reuse the previous product when sources repeat after a high form
      if (last_high_r && req.op == op_product_low && req.src_a == last_a_r
         && req.src_b == last_b_r)
         product = last_prod_r; // see RL14
      case (req.op)
         op_product_low: mul_result = product[w-1:0]; // see RL1
         op_product_word: mul_result =
            {{(w-word_width){product[word_width-1]}},
            product[word_width-1:0]}; // see RL3
         default: mul_result = product[2*w-1:w]; // see RL2
      endcase
   end

   // Divider operand preparation: magnitudes at operation width
   logic [w-1:0] dvd_ext;
   logic [w-1:0] dvs_ext;
   logic dvd_neg;
   logic dvs_neg;
   logic [w-1:0] dvd_mag;
   logic [w-1:0] dvs_mag;

   always_comb
   begin
      if (is_word)
      begin
         dvd_ext = is_signed ? {{(w-word_width){req.src_a[word_width-1]}},
            req.src_a[word_width-1:0]}
            : {{(w-word_width){1'b0}}, req.src_a[word_width-1:0]};
         dvs_ext = is_signed ? {{(w-word_width){req.src_b[word_width-1]}},
            req.src_b[word_width-1:0]}
            : {{(w-word_width){1'b0}}, req.src_b[word_width-1:0]};
      end
      else
      begin
         dvd_ext = req.src_a;
         dvs_ext = req.src_b;
      end
      dvd_neg = is_signed && dvd_ext[w-1];
      dvs_neg = is_signed && dvs_ext[w-1];
      dvd_mag = dvd_neg ? (~dvd_ext + 64'h0000000000000001) : dvd_ext;
      dvs_mag = dvs_neg ? (~dvs_ext + 64'h0000000000000001) : dvs_ext;
   end

   logic fuse_div;
   assign fuse_div = last_div_r && is_rem && is_signed == last_signed_r
      && is_word == last_word_r && req.src_a == last_a_r
      && req.src_b == last_b_r; // see RL15

   logic div_start;
   logic div_done;
   logic [w-1:0] div_q;
   logic [w-1:0] div_r;

   assign div_start = accept && is_div && !multiply_only_option && !fuse_div;

   unsigned_divider u_div
   (
      .clk(clk),
      .rst_n(rst_n),
      .start(div_start),
      .dividend(dvd_mag),
      .divisor(dvs_mag),
      .busy(),
      .done(div_done),
      .quotient(div_q),
      .remainder(div_r)
   );

   // Sign fix-up from the held request once the magnitudes are ready
   logic h_word;
   logic h_signed;
   logic h_dvd_neg;
   logic h_dvs_neg;
   logic h_zero;
   logic [w-1:0] h_dvd;
   logic [w-1:0] fix_q;
   logic [w-1:0] fix_r;

   always_comb
   begin
      h_word = (held_r.op inside {op_quotient_word_signed,
         op_quotient_word_unsigned, op_residue_word_signed,
         op_residue_word_unsigned});
      h_signed = (held_r.op inside {op_quotient_signed, op_residue_signed,
         op_quotient_word_signed, op_residue_word_signed});
      h_dvd = h_word ? {{(w-word_width){held_r.src_a[word_width-1]}},
         held_r.src_a[word_width-1:0]} : held_r.src_a;
      h_dvd_neg = h_signed && (h_word ? held_r.src_a[word_width-1]
         : held_r.src_a[w-1]);
      h_dvs_neg = h_signed && (h_word ? held_r.src_b[word_width-1]
         : held_r.src_b[w-1]);
      h_zero = h_word ? (held_r.src_b[word_width-1:0] == 32'h00000000)
         : (held_r.src_b == data_reset);
      // Rounding towards zero: negate magnitudes by operand signs
      fix_q = (h_dvd_neg ^ h_dvs_neg) ? (~div_q + 64'h0000000000000001)
         : div_q; // see RL4
      fix_r = h_dvd_neg ? (~div_r + 64'h0000000000000001) : div_r; // see RL5
      // Zero divisor: all ones and dividend, no trap raised
      if (h_zero)
      begin
         fix_q = {w{1'b1}}; // see RL9, RL12, RL17
         fix_r = h_dvd; // see RL10
      end
      // Overflow magnitude wraps back to the dividend, remainder is zero
      if (h_word)
      begin
         fix_q = {{(w-word_width){fix_q[word_width-1]}},
            fix_q[word_width-1:0]}; // see RL7, RL13
         fix_r = {{(w-word_width){fix_r[word_width-1]}},
            fix_r[word_width-1:0]}; // see RL8, RL11
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_r <= st_idle;
      else
         case (state_r)
            st_idle:
               if (div_start)
                  state_r <= st_div;
               else if (accept)
                  state_r <= st_answer;
            st_div:
               if (div_done)
                  state_r <= st_answer;
            default:
               state_r <= st_idle;
         endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_r <= data_reset;
         valid_r <= 1'b0;
         illegal_r <= 1'b0;
         held_r <= '0;
      end
      else
      begin
         valid_r <= 1'b0;
         if (accept)
         begin
            held_r <= req;
            illegal_r <= is_div && multiply_only_option; // see RL16
            if (is_mul)
               result_r <= mul_result;
            else if (multiply_only_option)
               result_r <= data_reset;
            else if (fuse_div)
               result_r <= is_word ? {{(w-word_width)
                  {last_rem_r[word_width-1]}}, last_rem_r[word_width-1:0]}
                  : last_rem_r;
            if (!div_start)
               valid_r <= 1'b1;
         end
         else if (state_r == st_div && div_done)
         begin
            result_r <= (held_r.op inside {op_residue_signed,
               op_residue_unsigned, op_residue_word_signed,
               op_residue_word_unsigned}) ? fix_r : fix_q; // see RL6
            valid_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_high_r <= 1'b0;
         last_div_r <= 1'b0;
         last_signed_r <= 1'b0;
         last_word_r <= 1'b0;
         last_a_r <= data_reset;
         last_b_r <= data_reset;
         last_prod_r <= '0;
         last_quot_r <= data_reset;
         last_rem_r <= data_reset;
      end
      else if (accept)
      begin
         last_a_r <= req.src_a;
         last_b_r <= req.src_b;
         last_prod_r <= product;
         last_high_r <= req.op inside {op_product_high_ss,
            op_product_high_uu, op_product_high_su}; // see RL14
         last_div_r <= 1'b0;
      end
      else if (state_r == st_div && div_done)
      begin
         last_div_r <= !(held_r.op inside {op_residue_signed,
            op_residue_unsigned, op_residue_word_signed,
            op_residue_word_unsigned}); // see RL15
         last_signed_r <= h_signed;
         last_word_r <= h_word;
         last_rem_r <= fix_r;
         last_quot_r <= fix_q;
      end
   end

   assign ans_valid = valid_r;
   assign ans.result = result_r;
   assign illegal_op = illegal_r;

   a_zero_quot: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == st_div && div_done && h_zero && !(held_r.op inside
      {op_residue_signed, op_residue_unsigned, op_residue_word_signed,
      op_residue_word_unsigned})) |=> result_r == {w{1'b1}}) // see RL9
      else $error("zero divisor quotient not all ones");

   a_low_product: assert property (@(posedge clk) disable iff (!rst_n)
      (accept && req.op == op_product_low) |=>
      ans_valid && result_r == $past(req.src_a * req.src_b)) // see RL1
      else $error("low product wrong");

   a_word_ext: assert property (@(posedge clk) disable iff (!rst_n)
      (accept && req.op == op_product_word) |=>
      result_r[w-1:word_width] == {(w-word_width){result_r[word_width-1]}})
      // see RL3
      else $error("word product not sign extended");

   a_div_latency: assert property (@(posedge clk) disable iff (!rst_n)
      div_start |-> ##[64:66] ans_valid) // see RL4
      else $error("divide answer late");

   a_zero_rem: assert property (@(posedge clk) disable iff (!rst_n) // see RL10
      (state_r == st_div && div_done && held_r.src_b == data_reset
      && held_r.op inside {op_residue_signed, op_residue_unsigned})
      |=> result_r == $past(held_r.src_a))
      else $error("zero divisor remainder not the dividend");

   a_overflow_quot: assert property (@(posedge clk) disable iff (!rst_n) // see RL11
      (state_r == st_div && div_done && held_r.op == op_quotient_signed
      && held_r.src_a == 64'h8000000000000000 && held_r.src_b == '1)
      |=> result_r == 64'h8000000000000000)
      else $error("overflow quotient not the dividend");

endmodule
`default_nettype wire

// ==== src/muldiv_pkg.sv ====
// Package for the integer multiply and divide unit: widths, operations and
// the request and answer carriers shared by the unit and its divider.
// Assumes a 64-bit register width; word forms act on the low 32 bits.
package muldiv_pkg;

   localparam int register_width = 64;
   localparam int word_width = 32;
   localparam int div_steps = register_width;
   localparam logic [6:0] step_count_reset = 7'h00;
   localparam logic [63:0] data_reset = 64'h0000000000000000;

   typedef enum logic [3:0]
   {
      op_product_low,
      op_product_high_ss,
      op_product_high_uu,
      op_product_high_su,
      op_product_word,
      op_quotient_signed,
      op_quotient_unsigned,
      op_residue_signed,
      op_residue_unsigned,
      op_quotient_word_signed,
      op_quotient_word_unsigned,
      op_residue_word_signed,
      op_residue_word_unsigned
   } op_t;

   typedef struct packed
   {
      op_t op;
      logic [register_width-1:0] src_a;
      logic [register_width-1:0] src_b;
   } request_t;

   typedef struct packed
   {
      logic [register_width-1:0] result;
   } answer_t;

endpackage

// ==== src/unsigned_divider.sv ====
// Unsigned restoring divider, one quotient bit per clock.
// Assumes a start pulse only while idle; operands are held internally.
`timescale 1ns/1ps
`default_nettype none
module unsigned_divider
   import muldiv_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [register_width-1:0] dividend,
   input wire logic [register_width-1:0] divisor,
   output logic busy,
   output logic done,
   output logic [register_width-1:0] quotient,
   output logic [register_width-1:0] remainder
);

   logic [6:0] count_r;
   logic [register_width-1:0] quot_r;
   logic [register_width-1:0] rem_r;
   logic [register_width-1:0] dvs_r;
   logic [register_width:0] trial;
   logic [register_width:0] shifted;

   assign shifted = {rem_r, quot_r[register_width-1]};
   assign trial = shifted - {1'b0, dvs_r};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= step_count_reset;
         quot_r <= data_reset;
         rem_r <= data_reset;
         dvs_r <= data_reset;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            count_r <= 7'(div_steps);
            quot_r <= dividend;
            rem_r <= data_reset;
            dvs_r <= divisor;
         end
         else if (count_r != step_count_reset)
         begin
            count_r <= count_r - 7'h01;
            // Divisor zero never subtracts less, so quotient ends all ones
            if (!trial[register_width])
            begin
               rem_r <= trial[register_width-1:0];
               quot_r <= {quot_r[register_width-2:0], 1'b1};
            end
            else
            begin
               rem_r <= shifted[register_width-1:0];
               quot_r <= {quot_r[register_width-2:0], 1'b0};
            end
            if (count_r == 7'h01)
               done <= 1'b1;
         end
      end
   end

   assign busy = (count_r != step_count_reset);
   assign quotient = quot_r;
   assign remainder = rem_r;

endmodule
`default_nettype wire

// ==== tb/issue_model.sv ====
// Issue-side model of the core pipeline: one request at a time.
// Assumes the caller enters issue at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module issue_model
   import muldiv_pkg::*;
(
   input wire logic clk,
   output logic req_valid,
   input wire logic req_ready,
   output var request_t req,
   input wire logic ans_valid,
   input wire answer_t ans,
   input wire logic illegal_op
);
   initial
   begin
      req_valid = 1'b0;
      req = '0;
   end

   task automatic issue(input op_t op, input logic [63:0] a,
      input logic [63:0] b, input int stall, output logic [63:0] res,
      output logic bad, output logic late);
      int n;
      begin
         n = 0;
         // One idle edge at least, so valid never falls and rises at once
         repeat (stall + 1) @(negedge clk);
         req_valid = 1'b1;
         req = '{op, a, b};
         // Ready depends on state only, so it is settled at the falling edge
         while (req_ready !== 1'b1 && n < 100)
         begin
            n++;
            @(negedge clk);
         end
         @(negedge clk);
         // Released request lines carry junk, not the last value
         req_valid = 1'b0;
         req = request_t'(~req);
         while (ans_valid !== 1'b1 && n < 200)
         begin
            n++;
            @(negedge clk);
         end
         res = ans.result;
         bad = illegal_op;
         late = (n >= 200);
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the multiply and divide unit.
// Assumes a 64-bit register width and a pipeline model on each unit.
`timescale 1ns/1ps
`default_nettype none
module tb
   import muldiv_pkg::*;
;
   logic clk;
   logic nrst;
   logic v0, r0, a0, i0, v1, r1, a1, i1;
   request_t q0, q1;
   answer_t s0, s1;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'h15A1;
   logic [63:0] ra, rb, hq, lr;
   logic [63:0] a_tab [6] = '{64'h8000000000000000, 64'h123456789ABCDEF0,
      -64'sd7, 64'd7, 64'h0000000080000000, '1};
   logic [63:0] b_tab [6] = '{'1, 64'h0, 64'd2, -64'sd2, 64'h00000000FFFFFFFF,
      '1};

   integer_mul_div_unit DUT (.clk(clk), .nrst(nrst), .req_valid(v0),
      .req_ready(r0), .req(q0), .ans_valid(a0), .ans(s0), .illegal_op(i0));
   integer_mul_div_unit #(.multiply_only_option(1'b1)) dut_mul_only (
      .clk(clk), .nrst(nrst), .req_valid(v1), .req_ready(r1), .req(q1),
      .ans_valid(a1), .ans(s1), .illegal_op(i1));
   issue_model pipe (.clk(clk), .req_valid(v0), .req_ready(r0), .req(q0),
      .ans_valid(a0), .ans(s0), .illegal_op(i0));
   issue_model pipe2 (.clk(clk), .req_valid(v1), .req_ready(r1), .req(q1),
      .ans_valid(a1), .ans(s1), .illegal_op(i1));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   function automatic logic [63:0] rnd();
      begin
         repeat (2) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
         return {seed, seed ^ 32'hA5C3E17B};
      end
   endfunction

   function automatic logic [63:0] expect_result(input op_t op,
      input logic [63:0] a, input logic [63:0] b);
      logic [127:0] sa, sb, ub, p;
      logic [31:0] x, y, w;
      logic [63:0] r;
      begin
         sa = {{64{a[63]}}, a};
         sb = {{64{b[63]}}, b};
         ub = {64'h0, b};
         x = a[31:0];
         y = b[31:0];
         w = 32'h0;
         r = 64'h0;
         p = 128'h0;
         case (op)
            op_product_low: r = a * b;
            op_product_high_ss: p = sa * sb;
            op_product_high_uu: p = {64'h0, a} * ub;
            op_product_high_su: p = sa * ub;
            op_product_word: w = x * y;
            op_quotient_signed:
               if (b == 0)
                  r = '1;
               else if (a == 64'h8000000000000000 && b == '1)
                  r = a;
               else
                  r = $signed(a) / $signed(b);
            op_residue_signed:
               if (b == 0)
                  r = a;
               else if (a == 64'h8000000000000000 && b == '1)
                  r = '0;
               else
                  r = $signed(a) % $signed(b);
            op_quotient_unsigned: r = (b == 0) ? '1 : a / b;
            op_residue_unsigned: r = (b == 0) ? a : a % b;
            op_quotient_word_signed:
               if (y == 0)
                  w = '1;
               else if (x == 32'h80000000 && y == '1)
                  w = x;
               else
                  w = $signed(x) / $signed(y);
            op_residue_word_signed:
               if (y == 0)
                  w = x;
               else if (x == 32'h80000000 && y == '1)
                  w = '0;
               else
                  w = $signed(x) % $signed(y);
            op_quotient_word_unsigned: w = (y == 0) ? '1 : x / y;
            default: w = (y == 0) ? x : x % y;
         endcase
         if (op inside {[op_product_high_ss:op_product_high_su]})
            r = p[127:64];
         if (op == op_product_word || op >= op_quotient_word_signed)
            r = {{32{w[31]}}, w};
         return r;
      end
   endfunction

   task automatic check(input string name, input logic [63:0] exp,
      input logic [63:0] got);
      begin
         n_checks++;
         if (got !== exp)
         begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_mismatch++;
         end
      end
   endtask

   task automatic run(input bit mo, input op_t op, input logic [63:0] a,
      input logic [63:0] b, output logic [63:0] res);
      logic bad, late, no_div;
      begin
         no_div = mo && op >= op_quotient_signed;
         if (mo)
            pipe2.issue(op, a, b, int'(seed[1:0]), res, bad, late);
         else
            pipe.issue(op, a, b, int'(seed[1:0]), res, bad, late);
         check(op.name(), no_div ? 64'h0 : expect_result(op, a, b), res);
         check("illegal_op", {63'h0, no_div}, {63'h0, bad});
         check("answer timeout", 64'h0, {63'h0, late});
      end
   endtask

   task automatic stop_test();
      begin
         if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end

   initial
   begin
      nrst = 1'b0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 6; i++)
         for (int o = 0; o < 13; o++)
            run(1'b0, op_t'(o), a_tab[i], b_tab[i], hq);
      for (int k = 0; k < 20; k++)
      begin
         ra = rnd();
         rb = rnd();
         for (int o = 0; o < 13; o++)
            run(1'b0, op_t'(o), ra, rb, hq);
         run(1'b0, op_product_high_su, ra, rb, hq);
         run(1'b0, op_product_low, ra, rb, lr);
         run(1'b0, op_quotient_signed, ra, rb, hq);
         run(1'b0, op_residue_signed, ra, rb, lr);
         check("identity", ra, hq * rb + lr);
      end
      for (int o = 0; o < 13; o++)
         run(1'b1, op_t'(o), ra, rb, hq);
      stop_test();
   end
endmodule
`default_nettype wire
